// ===== rtl/dscg_map.vh
`ifndef DSCG_MAP_VH
`define DSCG_MAP_VH

// Register byte offsets
`define DSCG_RUN_GATE_OFS       12'h100
`define DSCG_SLEEP_GATE_OFS     12'h110
`define DSCG_DEEP_GATE_OFS      12'h120
`define DSCG_ACTIVE_GATE_OFS    12'h130
`define DSCG_RUN_CFG_OFS        12'h140

// Gating register field positions
`define DSCG_PWM_BIT            20
`define DSCG_ADC_BIT            16
`define DSCG_WDT_BIT            3
`define DSCG_RATE_LSB           8
`define DSCG_RATE_MSB           9

// Run configuration field position
`define DSCG_AUTO_GATE_BIT      0

// Reset values
`define DSCG_GATE_RESET         32'h00000040
`define DSCG_CFG_RESET          32'h00000000

// Implemented (writable) bits of a gating register and of the run configuration
`define DSCG_GATE_MASK          32'h00110308
`define DSCG_CFG_MASK           32'h00000001

// Converter rate codes
`define DSCG_RATE_125K          2'h0
`define DSCG_RATE_250K          2'h1

// System operating states
`define DSCG_MODE_RUN           2'h0
`define DSCG_MODE_SLEEP         2'h1
`define DSCG_MODE_DEEP          2'h2

// Unit indices in the enable vectors
`define DSCG_UNIT_WDT           0
`define DSCG_UNIT_ADC           1
`define DSCG_UNIT_PWM           2

`endif

// ===== rtl/dscg_clk_gate.v
`timescale 1ns/1ps
`default_nettype none

// Glitch-free gate for one unit clock
module dscg_clk_gate
(
  input  wire  clk,
  input  wire  rst_n,
  input  wire  en,
  output wire  gclk,
  output wire  en_out
);

  reg en_q;

  // Enable moves on the falling edge, while the gated clock is low
  always @(negedge clk or negedge rst_n)
  begin
    if (!rst_n)
      en_q <= 1'b0;
    else
      en_q <= en;   // see [R15]
  end

  // High phase is cut short only by reset
  assign gclk   = clk & en_q;   // see [R1]
  assign en_out = en_q;

endmodule // dscg_clk_gate

`default_nettype wire

// ===== rtl/dscg_top.v
// Contract
// [R1] A set gating bit clocks its unit; a clear bit leaves the unit unclocked and disabled.
// [R2] An access to a unit whose clock is gated off is answered with a bus fault.
// [R3] Every unit gating bit is zero after reset, so all units start disabled.
// [R4] Software must set the gating bits of the units that the application needs.
// [R5] Run, sleep and deep-sleep gating registers exist, each used only in its own state; with auto gating off the code uses the run register in all states.
// [R6] The auto gating bit of the run configuration selects the sleep and deep-sleep registers.
// [R7] Bit 20 is a read-write clock enable for the pulse-width modulator, reset zero.
// [R8] Bit 16 is a read-write clock enable for converter module zero, reset zero.
// [R9] Bit 3 is a read-write clock enable for the watchdog, reset zero.
// [R10] Bits 9:8 pick the converter rate, one for 250k and zero for 125k samples/s, reset zero.
// [R11] The rate field can never raise the converter rate above the permitted maximum.
// [R12] Reserved bits read as zero and writes to them have no effect.
// [R13] Software should preserve reserved bits during read-modify-write updates.
// [R14] Bit positions without a unit behave as reserved bits.
// [R15] A unit clock enable changes only while the gated clock is low; reset clears the enable asynchronously, in either clock phase.
`timescale 1ns/1ps
`default_nettype none
`include "dscg_map.vh"

module dscg_top
#(
  parameter [1:0] MAX_RATE = `DSCG_RATE_250K,
  parameter       N_UNITS  = 3
)
(
  input  wire                pclk,
  input  wire                presetn,
  input  wire                psel,
  input  wire                penable,
  input  wire                pwrite,
  input  wire [11:0]         paddr,
  input  wire [31:0]         pwdata,
  output wire [31:0]         prdata,
  output wire                pready,
  output wire                pslverr,
  input  wire [1:0]          sys_mode,
  input  wire [N_UNITS-1:0]  unit_access,
  output wire [N_UNITS-1:0]  unit_bus_fault,
  output wire [N_UNITS-1:0]  unit_clk_en,
  output wire [N_UNITS-1:0]  unit_clk,
  output wire [1:0]          adc_rate_sel
);

  // Keeps only implemented bits of a gating word
  function [31:0] gate_clean;
    input [31:0] wval;
    begin
      gate_clean = wval & `DSCG_GATE_MASK;   // see [R12] see [R14]
    end
  endfunction

  // Limits a requested rate code to the permitted maximum
  function [1:0] rate_clamp;
    input [1:0] req;
    begin
      if (req > MAX_RATE)
        rate_clamp = MAX_RATE;   // see [R11]
      else
        rate_clamp = req;
    end
  endfunction

  // Cleans a gating write and clamps its rate field
  function [31:0] gate_write;
    input [31:0] wval;
    reg   [31:0] tmp;
    begin
      tmp = gate_clean(wval);
      tmp[`DSCG_RATE_MSB:`DSCG_RATE_LSB] =
        rate_clamp(wval[`DSCG_RATE_MSB:`DSCG_RATE_LSB]);   // see [R10]
      gate_write = tmp;
    end
  endfunction

  // Pulls the per-unit enables out of a gating word
  function [2:0] unit_bits;
    input [31:0] gval;
    begin
      unit_bits[`DSCG_UNIT_WDT] = gval[`DSCG_WDT_BIT];   // see [R9]
      unit_bits[`DSCG_UNIT_ADC] = gval[`DSCG_ADC_BIT];   // see [R8]
      unit_bits[`DSCG_UNIT_PWM] = gval[`DSCG_PWM_BIT];   // see [R7]
    end
  endfunction

  reg  [31:0]        run_gate_q;
  reg  [31:0]        sleep_gate_q;
  reg  [31:0]        deep_gate_q;
  reg  [31:0]        run_cfg_q;
  reg  [31:0]        prdata_q;
  reg  [N_UNITS-1:0] fault_q;
  reg  [1:0]         rate_q;
  reg  [31:0]        active_gate;
  reg  [31:0]        rd_mux;
  reg                addr_hit;

  wire               setup_ph;
  wire               write_ok;
  wire               auto_gate;
  wire [2:0]         active_units;
  wire [N_UNITS-1:0] gate_en;

  // APB phase decode
  assign setup_ph = psel & ~penable;
  assign write_ok = psel & penable & pwrite & addr_hit;
  assign auto_gate = run_cfg_q[`DSCG_AUTO_GATE_BIT];

  // Address decode, shared by write and error paths
  always @*
  begin
    case (paddr)
      `DSCG_RUN_GATE_OFS:    addr_hit = 1'b1;
      `DSCG_SLEEP_GATE_OFS:  addr_hit = 1'b1;
      `DSCG_DEEP_GATE_OFS:   addr_hit = 1'b1;
      `DSCG_ACTIVE_GATE_OFS: addr_hit = 1'b1;
      `DSCG_RUN_CFG_OFS:     addr_hit = 1'b1;
      default:               addr_hit = 1'b0;
    endcase
  end

  // Gating registers and run configuration
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_gate_q   <= gate_clean(`DSCG_GATE_RESET);   // see [R3]
      sleep_gate_q <= gate_clean(`DSCG_GATE_RESET);   // see [R3]
      deep_gate_q  <= gate_clean(`DSCG_GATE_RESET);   // see [R3]
      run_cfg_q    <= `DSCG_CFG_RESET;
    end
    else if (write_ok)
    begin
      case (paddr)
        `DSCG_RUN_GATE_OFS:
          run_gate_q <= gate_write(pwdata);
        `DSCG_SLEEP_GATE_OFS:
          sleep_gate_q <= gate_write(pwdata);
        `DSCG_DEEP_GATE_OFS:
          deep_gate_q <= gate_write(pwdata);
        `DSCG_RUN_CFG_OFS:
          run_cfg_q <= pwdata & `DSCG_CFG_MASK;
        default:
          run_cfg_q <= run_cfg_q;
      endcase
    end
  end

  // Picks the gating word for the current operating state
  always @*
  begin
    case (sys_mode)
      `DSCG_MODE_SLEEP:
        active_gate = auto_gate ? sleep_gate_q : run_gate_q;   // see [R5] see [R6]
      `DSCG_MODE_DEEP:
        active_gate = auto_gate ? deep_gate_q : run_gate_q;    // see [R5] see [R6]
      default:
        active_gate = run_gate_q;                              // see [R5]
    endcase
  end

  assign active_units = unit_bits(active_gate);

  // Read multiplexer; reserved bits are zero in every stored word
  always @*
  begin
    case (paddr)
      `DSCG_RUN_GATE_OFS:    rd_mux = run_gate_q;    // see [R12]
      `DSCG_SLEEP_GATE_OFS:  rd_mux = sleep_gate_q;  // see [R12]
      `DSCG_DEEP_GATE_OFS:   rd_mux = deep_gate_q;   // see [R12]
      `DSCG_ACTIVE_GATE_OFS: rd_mux = active_gate;
      `DSCG_RUN_CFG_OFS:     rd_mux = run_cfg_q;
      default:               rd_mux = 32'h00000000;
    endcase
  end

  // Read data captured in the setup phase, held through access
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (setup_ph && !pwrite)
      prdata_q <= rd_mux;
  end

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;
  assign prdata  = prdata_q;

  // Per-unit glitch-free clock gates
  genvar gi;
  generate
    for (gi = 0; gi < N_UNITS; gi = gi + 1)
    begin : g_unit
      dscg_clk_gate u_gate
      (
        .clk    (pclk),
        .rst_n  (presetn),
        .en     (active_units[gi]),   // see [R1]
        .gclk   (unit_clk[gi]),
        .en_out (gate_en[gi])
      );
    end
  endgenerate

  assign unit_clk_en = gate_en;

  // Faults an access to an unclocked unit
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fault_q <= {N_UNITS{1'b0}};
    else
      fault_q <= unit_access & ~gate_en;   // see [R2]
  end

  assign unit_bus_fault = fault_q;

  // Converter rate seen by the converter, following the active word
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rate_q <= `DSCG_RATE_125K;
    else
      rate_q <= rate_clamp(active_gate[`DSCG_RATE_MSB:`DSCG_RATE_LSB]);   // see [R11]
  end

  assign adc_rate_sel = rate_q;

endmodule // dscg_top

`default_nettype wire

// ===== bench/dscg_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port watcher for the gating block
module dscg_checker
#(
  parameter [1:0] MAX_RATE = 2'h1
)
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [2:0]  unit_access,
  input wire logic [2:0]  unit_bus_fault,
  input wire logic [2:0]  unit_clk_en,
  input wire logic [2:0]  unit_clk,
  input wire logic [1:0]  adc_rate_sel
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Read access qualifier
  wire rd_acc = psel && penable && !pwrite;
  property p_flt; $past(presetn) |-> unit_bus_fault == $past(unit_access & ~unit_clk_en); endproperty
  a_flt: assert property (p_flt) else $error("fault");
  property p_low; unit_clk == 3'h0; endproperty
  a_low: assert property (p_low) else $error("clk high");
  property p_high; @(negedge pclk) unit_clk == unit_clk_en; endproperty
  a_high: assert property (p_high) else $error("clk gate");
  property p_rst; $rose(presetn) |-> unit_clk_en == 3'h0 && adc_rate_sel == 2'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_max; adc_rate_sel <= MAX_RATE; endproperty
  a_max: assert property (p_max) else $error("rate");
  property p_rsv; rd_acc && paddr < 12'h140 |-> (prdata & 32'hFFEEFCF7) == 32'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved");
  property p_cfg; rd_acc && paddr == 12'h140 |-> prdata[31:1] == 31'h0; endproperty
  a_cfg: assert property (p_cfg) else $error("config");
  // Read data of a write holds the last read word, so only reads must show zero
  property p_err;
    psel && penable && paddr < 12'h100 |-> pslverr && (pwrite || prdata == 32'h0);
  endproperty
  a_err: assert property (p_err) else $error("unmapped");
endmodule // dscg_checker
bind dscg_top dscg_checker #(.MAX_RATE(MAX_RATE)) u_dscg_checker (.*);
`default_nettype wire

// ===== bench/dscg_units.sv
`timescale 1ns/1ps
`default_nettype none
// Gated units: bus hits and received clock pulses
module dscg_units
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire logic [2:0] req,
  input  wire logic [2:0] unit_clk,
  output var logic [2:0] unit_access,
  output var logic [2:0][7:0] ticks
);
  // Bus hit one cycle after request
  always @(posedge pclk or negedge presetn)
    if (!presetn) unit_access <= 3'h0;
    else unit_access <= req;
  // Pulse count per unit
  for (genvar i = 0; i < 3; i++)
  begin : g_tick
    always @(posedge unit_clk[i] or negedge presetn)
      if (!presetn) ticks[i] <= 8'h00;
      else ticks[i] <= ticks[i] + 8'h01;
  end
endmodule // dscg_units
`default_nettype wire

// ===== bench/dscg_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dscg_top_bench;
  typedef struct {logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} dscg_row_t;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  logic [1:0]      sys_mode, adc_rate_sel;
  logic [2:0]      req, unit_access, unit_bus_fault, unit_clk_en, unit_clk;
  logic [2:0][7:0] ticks, t0;
  int              n_errors = 0;
  int              checks = 0;
  dscg_row_t rows [7] = '{'{12'h120, 32'hFFFFFFFF, 32'h00110108, 1'b0},
    '{12'h120, 32'h00000200, 32'h00000100, 1'b0}, '{12'h120, 32'h00000108, 32'h00000108, 1'b0},
    '{12'h100, 32'h00010008, 32'h00010008, 1'b0}, '{12'h110, 32'h00100000, 32'h00100000, 1'b0},
    '{12'h140, 32'hFFFFFFFF, 32'h00000001, 1'b0}, '{12'h0FC, 32'h00000001, 32'h00000000, 1'b1}};
  logic [2:0]      en_x [4] = '{3'h3, 3'h4, 3'h1, 3'h3};
  logic [1:0]      rate_x [4] = '{2'h0, 2'h0, 2'h1, 2'h0};
  dscg_top u_dscg_top (.*);
  dscg_units u_dscg_units (.*);
  // Free-running clock
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // One APB transfer, waiting for pready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 20)
      begin
        n_errors++;
        give_verdict();
      end
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'h0;
    @(posedge pclk);
  endtask
  // Main sequence
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {sys_mode, req} = 5'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].a, 1'b1, rows[i].d, rd, err);
      chk(32'(err), 32'(rows[i].e));
      apb(rows[i].a, 1'b0, 32'h0, rd, err);
      chk(rd, rows[i].x);
    end
    $display("register rows done");
    for (int m = 0; m < 4; m++)
    begin
      sys_mode <= m[1:0];
      repeat (3) @(posedge pclk);
      chk(32'(unit_clk_en), 32'(en_x[m]));
      chk(32'(adc_rate_sel), 32'(rate_x[m]));
    end
    sys_mode <= 2'h2;
    repeat (3) @(posedge pclk);
    t0 = ticks;
    repeat (10) @(posedge pclk);
    chk(32'(ticks[0] - t0[0]), 32'h0000000A);
    chk(32'(ticks[2] - t0[2]), 32'h00000000);
    req <= 3'h7;
    @(posedge pclk);
    req <= 3'h0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'(unit_bus_fault), 32'h00000006);
    @(negedge pclk);
    chk(32'(unit_bus_fault), 32'h00000000);
    apb(12'h140, 1'b1, 32'h0, rd, err);
    repeat (3) @(posedge pclk);
    chk(32'(unit_clk_en), 32'h00000003);
    $display("mode and fault done");
    presetn <= 1'b0;
    @(negedge pclk);
    chk(32'({unit_clk_en, adc_rate_sel}), 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(12'h120, 1'b0, 32'h0, rd, err);
    chk(rd, 32'h00000000);
    // Read-modify-write keeps the reserved bits as read
    apb(12'h120, 1'b1, rd | 32'h00000008, rd, err);
    apb(12'h120, 1'b0, 32'h0, rd, err);
    chk(rd, 32'h00000008);
    $display("second reset done");
    give_verdict();
  end
endmodule // dscg_top_bench
`default_nettype wire
